// [tti_pkg.sv]
/*
 * Shared constants and types for the translation-cache invalidation issuer.
 * Assumes the invalidation target decodes the type codes and entry bit fields below.
 */
package tti_pkg;

	// Tag invalidation types
	localparam logic [1:0] TAG_INV_ADDR = 2'h0;
	localparam logic [1:0] TAG_INV_SINGLE = 2'h1;
	localparam logic [1:0] TAG_INV_ALL = 2'h2;
	localparam logic [1:0] TAG_INV_KEEP_GLOBAL = 2'h3;

	// Extended-table invalidation types
	localparam logic [1:0] EXT_INV_SINGLE = 2'h1;
	localparam logic [1:0] EXT_INV_ALL = 2'h2;

	// Global-pages enable position in the feature control word
	localparam int FEAT_GLOBAL_BIT = 4;

	// Extended-table entry fields
	localparam int PRIV_LSB = 0;
	localparam int PRIV_MSB = 2;
	localparam int MTYPE_LSB = 3;
	localparam int MTYPE_MSB = 5;
	localparam int IGNORE_PAT_BIT = 6;
	localparam int MAPS_PAGE_BIT = 7;
	localparam int ADDR_LSB = 12;
	localparam int ADDR_MSB = 51;

	// Reset value of the tag owner slots
	localparam logic OWN_VALID_RESET = 1'b0;

	// User-side requests
	typedef enum logic [2:0] {
		TTI_OP_EMU_PAGE,
		TTI_OP_EMU_TBASE,
		TTI_OP_EMU_FEAT,
		TTI_OP_GUEST_ENTRY,
		TTI_OP_VIRT_ENTER,
		TTI_OP_VIRT_LEAVE,
		TTI_OP_ENTRY_MOD
	} tti_op_t;

	// Level of a modified extended-table entry
	typedef enum logic [1:0] {
		TTI_LVL_UPPER,
		TTI_LVL_DIR,
		TTI_LVL_LEAF
	} tti_level_t;

endpackage

// [tti_chg_if.sv]
/*
 * Carrier between the issuer and its entry-change classifier.
 * Assumes both ends sit in the same clock domain; the path is combinational.
 */
`timescale 1ns/10ps
interface tti_chg_if;
	logic [63:0] old_entry; // Entry before the change
	logic [63:0] new_entry; // Entry after the change
	tti_pkg::tti_level_t level; // Paging level of the entry
	logic last; // Entry is the final one of a translation
	logic old_bad; // Old entry was misconfigured
	logic need; // Invalidation is required
	logic optional; // Invalidation is only advisable

	// Classifier end
	modport cls (
		input old_entry,
		input new_entry,
		input level,
		input last,
		input old_bad,
		output need,
		output optional
	);

	// Issuer end
	modport ctl (
		output old_entry,
		output new_entry,
		output level,
		output last,
		output old_bad,
		input need,
		input optional
	);
endinterface

// [tti_chg_cls.sv]
/*
 * Decides whether an extended-table entry change needs an invalidation.
 * Assumes present means any privilege bit set in the old entry.
 */
`timescale 1ns/10ps
module tti_chg_cls (
	// Change description and verdict
	tti_chg_if.cls chg
);
	logic old_present; // Old entry could have been cached
	logic priv_drop; // Some privilege went from 1 to 0
	logic priv_raise; // Some privilege went from 0 to 1
	logic addr_chg; // Physical address changed
	logic page_chg; // Page-mapping bit changed on an upper or directory level
	logic mtype_chg; // Memory-type fields changed on the final entry

	// Field comparisons
	always_comb
	begin
		old_present = |chg.old_entry[tti_pkg::PRIV_MSB:tti_pkg::PRIV_LSB];
		priv_drop = |(chg.old_entry[tti_pkg::PRIV_MSB:tti_pkg::PRIV_LSB]
			& ~chg.new_entry[tti_pkg::PRIV_MSB:tti_pkg::PRIV_LSB]);
		priv_raise = |(~chg.old_entry[tti_pkg::PRIV_MSB:tti_pkg::PRIV_LSB]
			& chg.new_entry[tti_pkg::PRIV_MSB:tti_pkg::PRIV_LSB]);
		addr_chg = chg.old_entry[tti_pkg::ADDR_MSB:tti_pkg::ADDR_LSB]
			!= chg.new_entry[tti_pkg::ADDR_MSB:tti_pkg::ADDR_LSB];
		page_chg = (chg.level != tti_pkg::TTI_LVL_LEAF)
			&& (chg.old_entry[tti_pkg::MAPS_PAGE_BIT] != chg.new_entry[tti_pkg::MAPS_PAGE_BIT]);
		mtype_chg = chg.last
			&& ((chg.old_entry[tti_pkg::MTYPE_MSB:tti_pkg::MTYPE_LSB]
			!= chg.new_entry[tti_pkg::MTYPE_MSB:tti_pkg::MTYPE_LSB])
			|| (chg.old_entry[tti_pkg::IGNORE_PAT_BIT] != chg.new_entry[tti_pkg::IGNORE_PAT_BIT]));
	end

	// Verdict; an absent or misconfigured old entry was never cached
	always_comb
	begin
		if (!old_present || chg.old_bad)
		begin
			chg.need = 1'b0;
			chg.optional = 1'b0;
		end
		else
		begin
			chg.need = priv_drop || addr_chg || page_chg || mtype_chg;
			chg.optional = priv_raise && !chg.need;
		end
	end
endmodule

// [tti_issuer.sv]
/*
 * Invalidation issuer: turns hypervisor events into tag and extended-table
 * invalidation commands towards the translation cache of processor 0; entry-change flushes go to each logical processor.
 * Assumes the cache takes a command on valid and ready and pulses done once it
 * has removed the entries, and that user requests are held until accepted.
 */
// Contract
// - Page emulation sends type 0 with address
// - Table-base emulation sends type 3 with tag
// - Global-enable change sends type 1 with tag
// - Never share tag across different page tables; checked only with extended tables off, while the tag holds its owner slot
// - Interrupt-page change: single-context tag flush first
// - All-context tag flush at enter or leave
// - Privilege drop or address change: extended flush
// - Page bit or memory-type change: extended flush
// - Privilege raise: extended flush only optional
// - Interrupt-page change: extended flush of pointer
// - All-context extended flush at enter or leave
// - Propagate extended flush to every logical processor; only entry-change flushes are repeated per processor here
`timescale 1ns/10ps
module tti_issuer #(
	parameter int TAG_W = 16, // Virtual processor tag width
	parameter int NUM_LP = 4, // Logical processors sharing the tables
	parameter int OWN_DEPTH = 8, // Tag owner slots, a power of two
	parameter bit ISSUE_OPTIONAL = 1'b0 // Also flush on privilege raise
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// User request
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire tti_pkg::tti_op_t req_op_i,
	input wire logic [TAG_W-1:0] req_tag_i,
	input wire logic [63:0] req_addr_i,
	input wire logic [63:0] req_base_i,
	input wire logic req_ext_en_i,
	input wire logic req_intc_was_on_i,
	input wire logic req_intc_on_i,
	input wire logic req_intc_addr_chg_i,
	input wire logic [63:0] req_old_i,
	input wire logic [63:0] req_new_i,
	input wire tti_pkg::tti_level_t req_level_i,
	input wire logic req_last_i,
	input wire logic req_old_bad_i,
	// User response
	output logic rsp_valid_o,
	output logic rsp_err_o,
	// Invalidation command towards the cache
	output logic inv_valid_o,
	input wire logic inv_ready_i,
	output logic inv_ext_o,
	output logic [1:0] inv_type_o,
	output logic [TAG_W-1:0] inv_tag_o,
	output logic [63:0] inv_operand_o,
	output logic [((NUM_LP > 1) ? $clog2(NUM_LP) : 1)-1:0] inv_lp_o,
	input wire logic inv_done_i
);
	localparam int LP_W = (NUM_LP > 1) ? $clog2(NUM_LP) : 1; // Processor index width
	localparam int OWN_IW = (OWN_DEPTH > 1) ? $clog2(OWN_DEPTH) : 1; // Owner slot index width
	localparam logic [LP_W-1:0] LP_LAST = LP_W'(NUM_LP - 1); // Highest processor index
	localparam logic [TAG_W-1:0] TAG_ZERO = '0; // The host's own tag

	// One invalidation command
	typedef struct packed {
		logic ext; // Extended-table command, else tag command
		logic [1:0] kind; // Invalidation type
		logic [TAG_W-1:0] tag; // Processor tag operand
		logic [63:0] opnd; // Linear address or table pointer
		logic all_lp; // Repeat on every logical processor
	} tti_cmd_t;

	// Which guest table base owns a tag
	typedef struct packed {
		logic valid; // Slot in use
		logic [TAG_W-1:0] tag; // Full tag held in the slot
		logic [63:0] base; // Page table base bound to it
	} tti_own_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ISSUE,
		ST_WAIT,
		ST_RESP
	} tti_state_t;

	// Whole state of the issuer
	typedef struct packed {
		tti_state_t state; // Sequencer state
		tti_cmd_t [1:0] cmds; // Pending commands, slot 0 on the pins
		logic [1:0] ncmd; // Commands still to issue
		logic [LP_W-1:0] lp; // Processor being served
		logic rsp_valid; // Response pulse
		logic rsp_err; // Request refused
		tti_own_t [OWN_DEPTH-1:0] own; // Tag owner table
	} tti_st_t;

	tti_st_t st; // Registered state
	tti_st_t next_st; // Next state
	tti_chg_if chg (); // Link to the entry classifier
	logic [OWN_IW-1:0] own_idx; // Owner slot of the request tag
	logic tag_clash; // Request would share a tag across tables

	// Builds one command
	function automatic tti_cmd_t mk_cmd(input logic ext, input logic [1:0] kind,
		input logic [TAG_W-1:0] tag, input logic [63:0] opnd, input logic all_lp);
		tti_cmd_t c;
		c.ext = ext;
		c.kind = kind;
		c.tag = tag;
		c.opnd = opnd;
		c.all_lp = all_lp;
		return c;
	endfunction

	// Entry classifier
	tti_chg_cls u_cls (
		.chg(chg)
	);

	// Feed the classifier from the request
	always_comb
	begin
		chg.old_entry = req_old_i;
		chg.new_entry = req_new_i;
		chg.level = req_level_i;
		chg.last = req_last_i;
		chg.old_bad = req_old_bad_i;
	end

	// Owner table lookup for the request tag
	always_comb
	begin
		own_idx = req_tag_i[OWN_IW-1:0];
		tag_clash = !req_ext_en_i && (req_tag_i != TAG_ZERO) && st.own[own_idx].valid
			&& (st.own[own_idx].tag == req_tag_i) && (st.own[own_idx].base != req_base_i);
	end

	// Next-state logic
	always_comb
	begin
		next_st = st;
		next_st.rsp_valid = 1'b0;
		unique case (st.state)
			ST_IDLE:
			begin
				if (req_valid_i)
				begin
					next_st.rsp_err = 1'b0;
					next_st.ncmd = 2'h0;
					next_st.lp = '0;
					next_st.state = ST_RESP;
					unique case (req_op_i)
						tti_pkg::TTI_OP_EMU_PAGE:
						begin
							// Emulated single-page invalidate, only reached when trapping
							next_st.cmds[0] = mk_cmd(1'b0, tti_pkg::TAG_INV_ADDR, req_tag_i, req_addr_i, 1'b0);
							next_st.ncmd = 2'h1;
						end
						tti_pkg::TTI_OP_EMU_TBASE:
						begin
							// Emulated table-base write keeps globals
							next_st.cmds[0] = mk_cmd(1'b0, tti_pkg::TAG_INV_KEEP_GLOBAL, req_tag_i, '0, 1'b0);
							next_st.ncmd = 2'h1;
						end
						tti_pkg::TTI_OP_EMU_FEAT:
						begin
							// Only a change of global-pages enable needs a flush
							if (req_old_i[tti_pkg::FEAT_GLOBAL_BIT] != req_new_i[tti_pkg::FEAT_GLOBAL_BIT])
							begin
								next_st.cmds[0] = mk_cmd(1'b0, tti_pkg::TAG_INV_SINGLE, req_tag_i, '0, 1'b0);
								next_st.ncmd = 2'h1;
							end
						end
						tti_pkg::TTI_OP_GUEST_ENTRY:
						begin
							if (tag_clash)
							begin
								// Refuse the entry, nothing is issued
								next_st.rsp_err = 1'b1;
							end
							else
							begin
								// Bind the tag to this table base
								if (!req_ext_en_i && (req_tag_i != TAG_ZERO))
								begin
									next_st.own[own_idx].valid = 1'b1;
									next_st.own[own_idx].tag = req_tag_i;
									next_st.own[own_idx].base = req_base_i;
								end
								// Interrupt page newly virtualized or moved
								if ((!req_intc_was_on_i && req_intc_on_i) || req_intc_addr_chg_i)
								begin
									if (req_tag_i != TAG_ZERO)
									begin
										next_st.cmds[0] = mk_cmd(1'b0, tti_pkg::TAG_INV_SINGLE, req_tag_i, '0, 1'b0);
										next_st.ncmd = 2'h1;
									end
									if (req_ext_en_i)
									begin
										if (req_tag_i != TAG_ZERO)
										begin
											next_st.cmds[1] = mk_cmd(1'b1, tti_pkg::EXT_INV_SINGLE, '0, req_addr_i, 1'b0);
											next_st.ncmd = 2'h2;
										end
										else
										begin
											next_st.cmds[0] = mk_cmd(1'b1, tti_pkg::EXT_INV_SINGLE, '0, req_addr_i, 1'b0);
											next_st.ncmd = 2'h1;
										end
									end
								end
							end
						end
						tti_pkg::TTI_OP_VIRT_ENTER,
						tti_pkg::TTI_OP_VIRT_LEAVE:
						begin
							// Fresh session: flush both caches and forget tag owners
							next_st.cmds[0] = mk_cmd(1'b0, tti_pkg::TAG_INV_ALL, '0, '0, 1'b0);
							next_st.cmds[1] = mk_cmd(1'b1, tti_pkg::EXT_INV_ALL, '0, '0, 1'b0);
							next_st.ncmd = 2'h2;
							for (int i = 0; i < OWN_DEPTH; i++)
							begin
								next_st.own[i].valid = tti_pkg::OWN_VALID_RESET;
							end
						end
						tti_pkg::TTI_OP_ENTRY_MOD:
						begin
							// Extended entry changed; pointer in the address operand
							if (chg.need || (ISSUE_OPTIONAL && chg.optional))
							begin
								next_st.cmds[0] = mk_cmd(1'b1, tti_pkg::EXT_INV_SINGLE, '0, req_addr_i, 1'b1);
								next_st.ncmd = 2'h1;
							end
						end
						default:
						begin
							// Unknown code: refuse
							next_st.rsp_err = 1'b1;
						end
					endcase
					if (next_st.ncmd != 2'h0)
					begin
						next_st.state = ST_ISSUE;
					end
				end
			end
			ST_ISSUE:
			begin
				// Hold the command until the cache takes it
				if (inv_ready_i)
				begin
					next_st.state = ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				// Next command only after the cache reports removal
				if (inv_done_i)
				begin
					if (st.cmds[0].all_lp && (st.lp != LP_LAST))
					begin
						// Same command on the next logical processor
						next_st.lp = LP_W'(st.lp + 1'b1);
						next_st.state = ST_ISSUE;
					end
					else
					begin
						next_st.lp = '0;
						next_st.cmds[0] = st.cmds[1];
						next_st.ncmd = st.ncmd - 2'h1;
						next_st.state = (st.ncmd == 2'h1) ? ST_RESP : ST_ISSUE;
					end
				end
			end
			ST_RESP:
			begin
				// One-cycle response, then accept again
				next_st.rsp_valid = 1'b1;
				next_st.state = ST_IDLE;
			end
		endcase
	end

	// State register; owner table empty after reset
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// Outputs
	always_comb
	begin
		req_ready_o = (st.state == ST_IDLE);
		rsp_valid_o = st.rsp_valid;
		rsp_err_o = st.rsp_err;
		inv_valid_o = (st.state == ST_ISSUE);
		inv_ext_o = st.cmds[0].ext;
		inv_type_o = st.cmds[0].kind;
		inv_tag_o = st.cmds[0].tag;
		inv_operand_o = st.cmds[0].opnd;
		inv_lp_o = st.lp;
	end
endmodule

// [tti_issuer_props.sv]
/*
 * Concurrent checks on the invalidation issuer ports.
 * Assumes one clock domain and the command encodings of tti_pkg.
 */
`timescale 1ns/10ps
module tti_issuer_props #(
	parameter int TAG_W = 16
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// User side
	input wire logic req_valid_i,
	input wire logic req_ready_o,
	input wire tti_pkg::tti_op_t req_op_i,
	input wire logic [TAG_W-1:0] req_tag_i,
	input wire logic rsp_valid_o,
	// Cache side
	input wire logic inv_valid_o,
	input wire logic inv_ready_i,
	input wire logic inv_ext_o,
	input wire logic [1:0] inv_type_o,
	input wire logic [TAG_W-1:0] inv_tag_o,
	input wire logic [63:0] inv_operand_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	// Operation and tag of the request in service
	typedef struct packed {tti_pkg::tti_op_t op; logic [TAG_W-1:0] tag;} tti_hold_t;
	tti_hold_t st, next_st;
	wire logic take = req_valid_i && req_ready_o;
	wire logic cmd = inv_valid_o && !inv_ext_o;
	// Capture the request when it is taken
	always_comb
	begin
		next_st = st;
		if (take)
			next_st = '{req_op_i, req_tag_i};
	end
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
			st <= '{tti_pkg::TTI_OP_VIRT_ENTER, '0};
		else
			st <= next_st;
	end
	req_hold_a: assert property (take |=> !req_ready_o) else $error("ready after take");
	cmd_hold_a: assert property (inv_valid_o && !inv_ready_i |=> inv_valid_o &&
		$stable({inv_ext_o, inv_type_o, inv_tag_o, inv_operand_o})) else $error("command moved");
	rsp_quiet_a: assert property (inv_valid_o |-> !rsp_valid_o) else $error("early response");
	page_start_a: assert property (take && req_op_i == tti_pkg::TTI_OP_EMU_PAGE |=> inv_valid_o)
		else $error("no page command");
	page_cmd_a: assert property (inv_valid_o && st.op == tti_pkg::TTI_OP_EMU_PAGE |-> cmd &&
		inv_type_o == tti_pkg::TAG_INV_ADDR && inv_tag_o == st.tag) else $error("bad page command");
	tbase_cmd_a: assert property (inv_valid_o && st.op == tti_pkg::TTI_OP_EMU_TBASE |-> cmd &&
		inv_type_o == tti_pkg::TAG_INV_KEEP_GLOBAL && inv_tag_o == st.tag) else $error("bad base command");
	feat_cmd_a: assert property (inv_valid_o && st.op == tti_pkg::TTI_OP_EMU_FEAT |-> cmd &&
		inv_type_o == tti_pkg::TAG_INV_SINGLE && inv_tag_o == st.tag) else $error("bad feature command");
	mod_cmd_a: assert property (inv_valid_o && st.op == tti_pkg::TTI_OP_ENTRY_MOD |-> inv_ext_o &&
		inv_type_o == tti_pkg::EXT_INV_SINGLE) else $error("bad entry command");
	all_pair_a: assert property (cmd && inv_ready_i && inv_type_o == tti_pkg::TAG_INV_ALL |=>
		##[1:60] (inv_valid_o && inv_ext_o && inv_type_o == tti_pkg::EXT_INV_ALL)) else $error("no ext flush");
	cover property (cmd && inv_type_o == tti_pkg::TAG_INV_ADDR);
	cover property (inv_valid_o && inv_ext_o && inv_type_o == tti_pkg::EXT_INV_ALL);
	cover property (take ##[1:40] rsp_valid_o);
endmodule

bind tti_issuer tti_issuer_props #(.TAG_W(TAG_W)) tti_issuer_props_i (.clk_sys_i(clk_sys_i),
	.reset_i(reset_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_op_i(req_op_i),
	.req_tag_i(req_tag_i), .rsp_valid_o(rsp_valid_o), .inv_valid_o(inv_valid_o), .inv_ready_i(inv_ready_i),
	.inv_ext_o(inv_ext_o), .inv_type_o(inv_type_o), .inv_tag_o(inv_tag_o), .inv_operand_o(inv_operand_o));

// [tti_cache_model.sv]
/*
 * Behavioural translation cache that accepts invalidation commands.
 * Assumes the issuer holds a command until ready and then waits for done.
 */
`timescale 1ns/10ps
module tti_cache_model (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Command and pacing
	input wire logic inv_valid_i,
	input wire logic slow_i,
	// Handshake back
	output logic inv_ready_o,
	output logic inv_done_o
);
	typedef struct packed {logic [3:0] cnt; logic busy; logic ready; logic done;} tti_cache_t;
	tti_cache_t st, next_st;
	wire logic [3:0] dly = slow_i ? 4'h3 : 4'h0;
	assign inv_ready_o = st.ready;
	assign inv_done_o = st.done;
	// Accept, remove, then report; every type is a full flush
	// Keeps no entries, so no tag, pointer or faulted mapping can go stale
	always_comb
	begin
		next_st = st;
		next_st.done = 1'b0;
		if (inv_valid_i && st.ready)
			next_st = '{4'h0, 1'b1, 1'b0, 1'b0};
		else if (st.busy)
		begin
			next_st.cnt = st.cnt + 4'h1;
			if (st.cnt == dly)
				next_st = '{4'h0, 1'b0, 1'b0, 1'b1};
		end
		else if (inv_valid_i)
		begin
			next_st.cnt = st.cnt + 4'h1;
			if (st.cnt >= dly)
				next_st = '{4'h0, 1'b0, 1'b1, 1'b0};
		end
	end
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
			st <= '0;
		else
			st <= next_st;
	end
endmodule

// [testbench.sv]
/*
 * Self-checking bench for the invalidation issuer with a cache model.
 * Assumes two logical processors, so the processor index is one bit.
 */
`timescale 1ns/10ps
module testbench;
	// Issuer ports
	logic clk_sys_i, reset_i, req_valid_i, req_ready_o, req_ext_en_i, req_intc_was_on_i, req_intc_on_i;
	logic req_intc_addr_chg_i, req_last_i, req_old_bad_i, rsp_valid_o, rsp_err_o;
	logic inv_valid_o, inv_ready_i, inv_ext_o, inv_done_i, slow;
	logic [0:0] inv_lp_o;
	logic [1:0] inv_type_o;
	logic [15:0] req_tag_i, inv_tag_o;
	logic [63:0] req_addr_i, req_base_i, req_old_i, req_new_i, inv_operand_o;
	tti_pkg::tti_op_t req_op_i;
	tti_pkg::tti_level_t req_level_i;
	logic [83:0] cq[$];
	int bad_count, checks_done;

	tti_issuer #(.TAG_W(16), .NUM_LP(2), .OWN_DEPTH(8), .ISSUE_OPTIONAL(1'b0)) tti_issuer_i (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
		.req_op_i(req_op_i), .req_tag_i(req_tag_i), .req_addr_i(req_addr_i), .req_base_i(req_base_i),
		.req_ext_en_i(req_ext_en_i), .req_intc_was_on_i(req_intc_was_on_i), .req_intc_on_i(req_intc_on_i),
		.req_intc_addr_chg_i(req_intc_addr_chg_i), .req_old_i(req_old_i), .req_new_i(req_new_i),
		.req_level_i(req_level_i), .req_last_i(req_last_i), .req_old_bad_i(req_old_bad_i),
		.rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o), .inv_valid_o(inv_valid_o), .inv_ready_i(inv_ready_i),
		.inv_ext_o(inv_ext_o), .inv_type_o(inv_type_o), .inv_tag_o(inv_tag_o), .inv_operand_o(inv_operand_o),
		.inv_lp_o(inv_lp_o), .inv_done_i(inv_done_i));
	tti_cache_model tti_cache_model_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .inv_valid_i(inv_valid_o),
		.slow_i(slow), .inv_ready_o(inv_ready_i), .inv_done_o(inv_done_i));

	// Log each command as the cache takes it
	always @(posedge clk_sys_i)
		if (inv_valid_o === 1'b1 && inv_ready_i === 1'b1)
			cq.push_back({inv_ext_o, inv_type_o, inv_tag_o, inv_operand_o, inv_lp_o});

	initial
	begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	task automatic final_report();
		if (bad_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [83:0] e, input logic [83:0] g);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One request: hold until taken, wait for the answer, judge count and error
	task automatic go(input int nc, input logic er);
		int t;
		t = 0;
		cq.delete();
		@(negedge clk_sys_i);
		req_valid_i = 1'b1;
		while (req_ready_o !== 1'b1 && t < 50)
		begin
			@(negedge clk_sys_i);
			t++;
		end
		@(negedge clk_sys_i);
		req_valid_i = 1'b0;
		while (rsp_valid_o !== 1'b1 && t < 100)
		begin
			@(negedge clk_sys_i);
			t++;
		end
		if (t >= 100)
		begin
			bad_count++;
			final_report();
		end
		else
		begin
			chk("count", nc, cq.size());
			chk("error", er, rsp_err_o);
		end
	endtask

	task automatic s_page();
		req_op_i = tti_pkg::TTI_OP_EMU_PAGE;
		req_tag_i = 16'h1234;
		req_addr_i = 64'h0000_7FFF_F000_1000;
		go(1, 1'b0);
		chk("page", {1'b0, 2'h0, 16'h1234, 64'h0000_7FFF_F000_1000, 1'b0}, cq[0]);
	endtask

	task automatic s_tbase();
		slow = 1'b1;
		req_op_i = tti_pkg::TTI_OP_EMU_TBASE;
		go(1, 1'b0);
		chk("tbase", {1'b0, 2'h3, 16'h1234, 64'h0, 1'b0}, cq[0]);
	endtask

	task automatic s_feat();
		slow = 1'b0;
		req_op_i = tti_pkg::TTI_OP_EMU_FEAT;
		req_new_i = 64'h10;
		go(1, 1'b0);
		chk("feat", {1'b0, 2'h1, 16'h1234, 64'h0, 1'b0}, cq[0]);
		req_old_i = 64'h10;
		req_new_i = 64'h30;
		go(0, 1'b0);
	endtask

	// Enter then leave, each with both all-context flushes
	task automatic s_enter();
		slow = 1'b1;
		req_tag_i = 16'h0;
		for (int i = 0; i < 2; i++)
		begin
			req_op_i = i ? tti_pkg::TTI_OP_VIRT_LEAVE : tti_pkg::TTI_OP_VIRT_ENTER;
			go(2, 1'b0);
			chk("all_tag", {1'b0, 2'h2, 80'h0, 1'b0}, cq[0]);
			chk("all_ext", {1'b1, 2'h2, 80'h0, 1'b0}, cq[1]);
		end
	endtask

	task automatic s_guest();
		req_op_i = tti_pkg::TTI_OP_GUEST_ENTRY;
		req_tag_i = 16'h0005;
		req_base_i = 64'h1000;
		go(0, 1'b0);
		req_base_i = 64'h2000;
		go(0, 1'b1);
		req_tag_i = 16'h0007;
		req_addr_i = 64'h0000_000A_BCDE_F000;
		{req_ext_en_i, req_intc_on_i} = 2'h3;
		go(2, 1'b0);
		chk("intc_tag", {1'b0, 2'h1, 16'h0007, 64'h0, 1'b0}, cq[0]);
		chk("intc_ext", {1'b1, 2'h1, 16'h0, 64'h0000_000A_BCDE_F000, 1'b0}, cq[1]);
		// Interrupt page moved under tag zero: pointer flush only
		{req_intc_was_on_i, req_intc_addr_chg_i} = 2'h3;
		req_tag_i = 16'h0;
		go(1, 1'b0);
		chk("intc_ptr", {1'b1, 2'h1, 16'h0, 64'h0000_000A_BCDE_F000, 1'b0}, cq[0]);
		// Already virtualized and not moved: nothing to flush
		req_intc_addr_chg_i = 1'b0;
		req_tag_i = 16'h0007;
		go(0, 1'b0);
		{req_ext_en_i, req_intc_on_i, req_intc_was_on_i} = 3'h0;
	endtask

	// Entry changes: drop, page bit, address, memory type, raise, bad, absent,
	// page bit on an upper entry, bit 7 on a leaf (not a page-mapping bit there)
	task automatic s_mod();
		logic [15:0] ov[9] = '{16'h3007, 16'h3007, 16'h3007, 16'h3007, 16'h3003,
			16'h3007, 16'h3000, 16'h3007, 16'h3007};
		logic [15:0] nv[9] = '{16'h3003, 16'h3087, 16'h4007, 16'h3037, 16'h3007,
			16'h3003, 16'h3004, 16'h3087, 16'h3087};
		logic [8:0] hit = 9'h08F;
		req_op_i = tti_pkg::TTI_OP_ENTRY_MOD;
		for (int i = 0; i < 9; i++)
		begin
			req_old_i = {48'h0, ov[i]};
			req_new_i = {48'h0, nv[i]};
			req_level_i = tti_pkg::TTI_LVL_LEAF;
			if (i == 1)
				req_level_i = tti_pkg::TTI_LVL_DIR;
			if (i == 7)
				req_level_i = tti_pkg::TTI_LVL_UPPER;
			req_last_i = (i != 1) && (i != 7);
			req_old_bad_i = (i == 5);
			go(hit[i] ? 2 : 0, 1'b0);
			if (hit[i])
			begin
				chk("lp0", {1'b1, 2'h1, 16'h0, 64'h0000_000A_BCDE_F000, 1'b0}, cq[0]);
				chk("lp1", {1'b1, 2'h1, 16'h0, 64'h0000_000A_BCDE_F000, 1'b1}, cq[1]);
			end
		end
	endtask

	initial
	begin
		reset_i = 1'b1;
		req_valid_i = 1'b0;
		req_op_i = tti_pkg::TTI_OP_EMU_PAGE;
		req_level_i = tti_pkg::TTI_LVL_LEAF;
		{req_ext_en_i, req_intc_was_on_i, req_intc_on_i, req_intc_addr_chg_i, req_last_i, req_old_bad_i} = '0;
		{req_tag_i, req_addr_i, req_base_i, req_old_i, req_new_i, slow} = '0;
		bad_count = 0;
		checks_done = 0;
		repeat (2) @(negedge clk_sys_i);
		chk("reset", 4'h8, {req_ready_o, inv_valid_o, rsp_valid_o, rsp_err_o});
		reset_i = 1'b0;
		s_page();
		s_tbase();
		s_feat();
		s_enter();
		s_guest();
		s_mod();
		final_report();
	end
endmodule
